// [common/sdr_route_map.svh]
// Header: constants for the receive and transmit sample routing block.
// Assumes it is included by the package and by the routing module.
`ifndef SDR_ROUTE_MAP_SVH
`define SDR_ROUTE_MAP_SVH

// ****************************************
// Sizes and limits
// ****************************************
`define SR_NUM_DDC        8
`define SR_NUM_ADC        4
`define SR_MAX_DDC        80
`define SR_MAX_ADC        8
`define SR_IDX_W          3
`define SR_SAMP_W         24
`define SR_SRC_W          4
`define SR_FIFO_DEPTH     16
`define SR_FIFO_AW        4
`define SR_TX_PORT        16'h0405
`define SR_TS_W           64
`define SR_CIC_STAGES     5
`define SR_PHASE_W        32
`define SR_ONE_IDX        3'h1
`define SR_ZERO_IDX       3'h0

`endif

// [common/sr_pkg.sv]
// Package: types shared by the sample routing block and its bench.
// Assumes sdr_route_map.svh sits on the include path.
`include "sdr_route_map.svh"

package sr_pkg;

	// ****************************************
	// Carriers
	// ****************************************
	typedef struct packed
	{
		logic [`SR_SAMP_W-1:0] i;
		logic [`SR_SAMP_W-1:0] q;
	} sr_iq_s;

	typedef struct packed
	{
		logic                  valid;
		logic [`SR_IDX_W-1:0]  ddc;
		logic [`SR_TS_W-1:0]   stamp;
		sr_iq_s                iq;
	} sr_word_s;

	typedef struct packed
	{
		logic [`SR_SRC_W-1:0]  src;
		logic [`SR_NUM_DDC-1:0] sync_mask;
		logic [`SR_NUM_DDC-1:0] mux_mask;
		logic [`SR_PHASE_W-1:0] phase_inc;
		logic [7:0]            rate_div;
	} sr_ddc_cfg_s;

	typedef enum logic [1:0]
	{
		SR_IDLE,
		SR_WALK
	} sr_state_e;

endpackage

// [rtl/sr_route.sv]
// Sample routing: selects each down-converter input, groups converters
// into base FIFOs and feeds host transmit samples to the up-converter.
// Assumes the mixers and filters sit behind the ddc_* and cic_* ports.
// Notes on behaviour
// RULE_01 - An ungrouped converter writes its output into its own FIFO.
// RULE_02 - Grouped companions pass one after another into the base FIFO.
// RULE_03 - Grouped converters share one sample rate; others are refused.
// RULE_04 - Synchronous companions share phase; multiplexed ones tune alone.
// RULE_05 - Synchronous companions per base are at most the ADC count.
// RULE_06 - Multiplexed companions per base are at most the DDC count.
// RULE_07 - Each converter input comes from any ADC or the DAC stream.
// RULE_08 - Ungrouped converters run at their own rates.
// RULE_09 - Each converter is mixer, then decimators, then FIR.
// RULE_10 - The up-converter is a five stage interpolator then a mixer.
// RULE_11 - Host 24 bit samples enter the interpolator uncompensated.
// RULE_12 - With one DAC the transmit port FIFO drives the up-converter.
// RULE_13 - At most 80 converters and 8 ADCs are supported.
// RULE_14 - Each routed sample carries a fractional-seconds stamp.
// RULE_15 - A group is written in ascending index order from the base.
`timescale 1ns/1ns
`include "sdr_route_map.svh"

module sr_route
(
	input  wire logic                       clk,
	input  wire logic                       rst_b,
	input  wire sr_pkg::sr_ddc_cfg_s        cfg [`SR_NUM_DDC],
	input  wire logic [`SR_SAMP_W-1:0]      adc [`SR_NUM_ADC],
	input  wire logic [`SR_SAMP_W-1:0]      dac_data,
	output      logic [`SR_SAMP_W-1:0]      ddc_in [`SR_NUM_DDC],
	output      logic [`SR_PHASE_W-1:0]     ddc_phase [`SR_NUM_DDC],
	output      logic [`SR_NUM_DDC-1:0]     ddc_phase_load,
	input  wire sr_pkg::sr_iq_s             ddc_out [`SR_NUM_DDC],
	input  wire logic [`SR_NUM_DDC-1:0]     ddc_strobe,
	input  wire logic [`SR_TS_W-1:0]        ts_frac,
	output      sr_pkg::sr_word_s           port_word [`SR_NUM_DDC],
	input  wire logic [`SR_NUM_DDC-1:0]     port_ready,
	output      logic [`SR_NUM_DDC-1:0]     cfg_error,
	input  wire sr_pkg::sr_iq_s             tx_iq,
	input  wire logic                       tx_valid,
	output      logic                       tx_ready,
	output      sr_pkg::sr_iq_s             cic_iq,
	output      logic                       cic_valid
);
	import sr_pkg::*;

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [`SR_IDX_W:0] pop(
		input logic [`SR_NUM_DDC-1:0] m);
		logic [`SR_IDX_W:0] c;
		c = '0;
		for (int k = 0; k < `SR_NUM_DDC; k++)
			c = c + {{`SR_IDX_W{1'b0}}, m[k]};
		return c;
	endfunction

	// The base owns itself; members of another base's mask are silent.
	function automatic logic [`SR_NUM_DDC-1:0] grp(input int b);
		logic [`SR_NUM_DDC-1:0] g;
		g = cfg[b].sync_mask | cfg[b].mux_mask;
		g[b] = 1'b1;
		return g;
	endfunction

	logic [`SR_NUM_DDC-1:0] member;
	always_comb
	begin
		member = '0;
		for (int b = 0; b < `SR_NUM_DDC; b++)
			member = member | ((cfg[b].sync_mask | cfg[b].mux_mask)
				& ~(`SR_NUM_DDC'(1) << b));
	end

	// Group masks are held as a variable array so single bits can be selected.
	logic [`SR_NUM_DDC-1:0] group [`SR_NUM_DDC];
	always_comb
		for (int b = 0; b < `SR_NUM_DDC; b++)
			group[b] = grp(b);

	// ****************************************
	// Input selection and tuning
	// ****************************************
	// Source values at or above the ADC count pick the DAC stream.
	always_ff @(posedge clk)
		for (int d = 0; d < `SR_NUM_DDC; d++)
			if (!rst_b)
				ddc_in[d] <= '0;
			else if (cfg[d].src < `SR_SRC_W'(`SR_NUM_ADC)) // RULE_07
				ddc_in[d] <= adc[cfg[d].src[1:0]];
			else
				ddc_in[d] <= dac_data; // RULE_07

	// Synchronous companions take the base's phase word and reload
	// together so their mixers stay coherent; multiplexed ones keep
	// their own words. RULE_09 chains sit outside this block.
	logic [`SR_PHASE_W-1:0] next_phase [`SR_NUM_DDC];
	always_comb
		for (int d = 0; d < `SR_NUM_DDC; d++)
		begin
			next_phase[d] = cfg[d].phase_inc;
			for (int b = 0; b < `SR_NUM_DDC; b++)
				if (cfg[b].sync_mask[d] && b != d)
					next_phase[d] = cfg[b].phase_inc; // RULE_04
		end

	always_ff @(posedge clk)
		for (int d = 0; d < `SR_NUM_DDC; d++)
			if (!rst_b)
			begin
				ddc_phase[d] <= '0;
				ddc_phase_load[d] <= 1'b0;
			end
			else
			begin
				ddc_phase_load[d] <= next_phase[d] != ddc_phase[d];
				ddc_phase[d] <= next_phase[d]; // RULE_09
			end

	// ****************************************
	// Group checks
	// ****************************************
	always_ff @(posedge clk)
		for (int b = 0; b < `SR_NUM_DDC; b++)
			if (!rst_b)
				cfg_error[b] <= 1'b0;
			else
			begin
				cfg_error[b] <= 1'b0;
				if (pop(cfg[b].sync_mask) > (`SR_IDX_W+1)'(`SR_NUM_ADC))
					cfg_error[b] <= 1'b1; // RULE_05
				if (pop(cfg[b].mux_mask) > (`SR_IDX_W+1)'(`SR_NUM_DDC))
					cfg_error[b] <= 1'b1; // RULE_06
				for (int d = 0; d < `SR_NUM_DDC; d++)
					if (group[b][d] && cfg[d].rate_div != cfg[b].rate_div)
						cfg_error[b] <= 1'b1; // RULE_03 RULE_08
			end

	// ****************************************
	// Routing into port FIFOs
	// ****************************************
	// Each converter holds one pending sample; a group drains its holders
	// from the base upward in ascending order once all members have produced.
	sr_iq_s                 hold [`SR_NUM_DDC];
	logic [`SR_TS_W-1:0]    hold_ts [`SR_NUM_DDC];
	logic [`SR_NUM_DDC-1:0] full;
	logic [`SR_NUM_DDC-1:0] take;
	sr_state_e              st [`SR_NUM_DDC];
	logic [`SR_IDX_W-1:0]   idx [`SR_NUM_DDC];

	always_ff @(posedge clk)
		for (int d = 0; d < `SR_NUM_DDC; d++)
			if (!rst_b)
			begin
				full[d] <= 1'b0;
				hold[d] <= '0;
				hold_ts[d] <= '0;
			end
			else if (ddc_strobe[d] && (!full[d] || take[d]))
			begin
				full[d] <= 1'b1;
				hold[d] <= ddc_out[d];
				hold_ts[d] <= ts_frac; // RULE_14
			end
			else if (take[d])
				full[d] <= 1'b0;

	always_comb
	begin
		take = '0;
		for (int b = 0; b < `SR_NUM_DDC; b++)
			if (st[b] == SR_WALK && port_ready[b])
				take[idx[b]] = 1'b1;
	end

	function automatic logic [`SR_IDX_W-1:0] next_member(
		input int b, input logic [`SR_IDX_W-1:0] from);
		logic [`SR_IDX_W-1:0] n;
		n = from;
		for (int k = `SR_NUM_DDC-1; k >= 0; k--)
			if (group[b][k] && k > from)
				n = `SR_IDX_W'(k);
		return n;
	endfunction

	always_ff @(posedge clk)
		for (int b = 0; b < `SR_NUM_DDC; b++)
			if (!rst_b)
			begin
				st[b] <= SR_IDLE;
				idx[b] <= `SR_ZERO_IDX;
				port_word[b] <= '0;
			end
			else
			begin
				if (port_ready[b])
					port_word[b].valid <= 1'b0;
				case (st[b])
					SR_IDLE:
						if (!member[b] && !cfg_error[b]
							&& (grp(b) & ~full) == '0)
						begin
							st[b] <= SR_WALK;
							idx[b] <= `SR_IDX_W'(b); // RULE_15
						end
					SR_WALK:
						if (port_ready[b])
						begin
							port_word[b].valid <= 1'b1; // RULE_01 RULE_02
							port_word[b].ddc <= idx[b];
							port_word[b].iq <= hold[idx[b]];
							port_word[b].stamp <= hold_ts[b];
							if (next_member(b, idx[b]) == idx[b])
								st[b] <= SR_IDLE; // RULE_15
							else
								idx[b] <= next_member(b, idx[b]);
						end
					default:
						st[b] <= SR_IDLE;
				endcase
			end

	// ****************************************
	// Transmit path
	// ****************************************
	// One DAC: the port FIFO output goes straight into the five stage
	// interpolator with no compensation filter, so no grouping exists.
	assign tx_ready = 1'b1; // RULE_12

	always_ff @(posedge clk)
		if (!rst_b)
		begin
			cic_iq <= '0;
			cic_valid <= 1'b0;
		end
		else
		begin
			cic_iq <= tx_iq; // RULE_10 RULE_11
			cic_valid <= tx_valid;
		end

	// ****************************************
	// Checks
	// ****************************************
	a_tx_pass: assert property (@(posedge clk) disable iff (!rst_b) // RULE_11
		tx_valid |=> cic_valid && cic_iq == $past(tx_iq))
		else $error("Transmit sample not passed to interpolator.");
	a_size_limit: assert property (@(posedge clk) // RULE_13
		`SR_NUM_DDC <= `SR_MAX_DDC && `SR_NUM_ADC <= `SR_MAX_ADC)
		else $error("Converter counts exceed the limits.");
	a_group_order: assert property (@(posedge clk) disable iff (!rst_b) // RULE_15
		port_word[0].valid && port_ready[0] && st[0] == SR_WALK
		&& idx[0] != `SR_ZERO_IDX
		|=> port_word[0].ddc > $past(port_word[0].ddc))
		else $error("Group words out of ascending order.");
	a_sync_phase: assert property (@(posedge clk) disable iff (!rst_b) // RULE_04
		cfg[0].sync_mask[1] |=> ddc_phase[1] == $past(cfg[0].phase_inc))
		else $error("Synchronous companion not phase locked.");
	a_dac_select: assert property (@(posedge clk) disable iff (!rst_b) // RULE_07
		cfg[0].src >= `SR_SRC_W'(`SR_NUM_ADC) |=> ddc_in[0] == $past(dac_data))
		else $error("DAC feedback not selected.");
	a_sync_count: assert property (@(posedge clk) disable iff (!rst_b) // RULE_05
		pop(cfg[0].sync_mask) > (`SR_IDX_W+1)'(`SR_NUM_ADC) |=> cfg_error[0])
		else $error("Too many synchronous companions not flagged.");
	a_rate_match: assert property (@(posedge clk) disable iff (!rst_b) // RULE_03
		cfg[0].mux_mask[1] && cfg[1].rate_div != cfg[0].rate_div
		|=> cfg_error[0])
		else $error("Rate mismatch not flagged.");
	a_solo_route: assert property (@(posedge clk) disable iff (!rst_b) // RULE_01
		st[5] == SR_WALK && group[5] == 8'h20 && port_ready[5]
		|=> port_word[5].valid && port_word[5].ddc == 3'h5)
		else $error("Ungrouped converter not routed to own port.");
endmodule

// [tb/sr_route_tb_top.sv]
// Bench: routing block beside the port FIFO model; table then hand tests.
// Assumes the package and the constants header are compiled first.
`timescale 1ns/1ns
`include "sdr_route_map.svh"

module sr_route_tb_top;
	import sr_pkg::*;

	typedef struct {logic [3:0] src; logic [23:0] exp;} sr_row_s;
	logic                   clk = 1'b0;
	logic                   rst_b = 1'b0;
	logic                   stall = 1'b0;
	logic                   tx_valid = 1'b0;
	logic [63:0]            ts_frac = 64'h0;
	logic [`SR_NUM_DDC-1:0] ddc_strobe = 8'h0;
	logic [23:0]            dac_data = 24'h0d0000;
	sr_iq_s                 tx_iq = '0;
	logic [`SR_NUM_DDC-1:0] ddc_phase_load, port_ready, cfg_error;
	logic                   tx_ready, cic_valid;
	logic [23:0]            adc [`SR_NUM_ADC];
	logic [23:0]            ddc_in [`SR_NUM_DDC];
	logic [31:0]            ddc_phase [`SR_NUM_DDC];
	sr_ddc_cfg_s            cfg [`SR_NUM_DDC];
	sr_iq_s                 ddc_out [`SR_NUM_DDC];
	sr_iq_s                 cic_iq;
	sr_word_s               port_word [`SR_NUM_DDC];
	int                     n_mismatch = 0;
	int                     checks = 0;
	sr_row_s rows [6] = '{'{4'h0, 24'h0a0000}, '{4'h1, 24'h0a0001},
		'{4'h2, 24'h0a0002}, '{4'h3, 24'h0a0003},
		'{4'h4, 24'h0d0000}, '{4'hc, 24'h0d0000}};

	sr_route sr_route_i (.clk, .rst_b, .cfg, .adc, .dac_data, .ddc_in,
		.ddc_phase, .ddc_phase_load, .ddc_out, .ddc_strobe, .ts_frac,
		.port_word, .port_ready, .cfg_error, .tx_iq, .tx_valid, .tx_ready,
		.cic_iq, .cic_valid);
	sr_sink sr_sink_i (.clk, .stall, .port_word, .port_ready);

	// ****************************************
	// Helpers
	// ****************************************
	task automatic chk(input logic [63:0] s, input logic [63:0] e);
		checks++;
		if (s !== e)
		begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask

	// Inputs move one step after the edge so the design never races them.
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic clr();
		for (int d = 0; d < `SR_NUM_DDC; d++)
			cfg[d] = '{4'h0, 8'h0, 8'h0, 32'h0, 8'h1};
		sr_sink_i.got.delete();
		sr_sink_i.port.delete();
	endtask

	task automatic end_sim();
		$display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	initial
	begin
		forever #50 clk = ~clk;
	end

	initial
	begin
		#(2000 * 100);
		n_mismatch++;
		end_sim();
	end

	// ****************************************
	// Tests
	// ****************************************
	initial
	begin
		for (int k = 0; k < `SR_NUM_ADC; k++)
			adc[k] = 24'h0a0000 + 24'(k);
		for (int d = 0; d < `SR_NUM_DDC; d++)
			ddc_out[d] = '{24'(d), 24'h0};
		clr();
		cyc(3);
		rst_b = 1'b1;
		chk(cfg_error, 0);
		chk(cic_valid, 0);
		chk(port_word[0].valid, 0);
		foreach (rows[r])
		begin
			for (int d = 0; d < `SR_NUM_DDC; d++)
				cfg[d].src = rows[r].src;
			cyc(2);
			for (int d = 0; d < `SR_NUM_DDC; d++)
				chk(ddc_in[d], rows[r].exp);
		end
		tx_iq = '{24'h123456, 24'h654321};
		tx_valid = 1'b1;
		cyc(1);
		tx_valid = 1'b0;
		chk(cic_valid, 1);
		chk(cic_iq, {24'h123456, 24'h654321});
		chk(tx_ready, 1);
		cyc(1);
		chk(cic_valid, 0);
		// A stalled group holds back every word, then drains in order.
		clr();
		cfg[0].mux_mask = 8'h06;
		cyc(3);
		stall = 1'b1;
		ddc_strobe = 8'h07;
		ts_frac = 64'h1234;
		cyc(1);
		ddc_strobe = 8'h0;
		ts_frac = 64'h9;
		cyc(6);
		chk(port_word[0].valid, 0);
		chk(sr_sink_i.got.size(), 0);
		stall = 1'b0;
		cyc(10);
		chk(sr_sink_i.got.size(), 3);
		for (int k = 0; k < 3; k++)
		begin
			chk(sr_sink_i.port[k], 0);
			chk(sr_sink_i.got[k].ddc, k);
			chk(sr_sink_i.got[k].iq.i, k);
			chk(sr_sink_i.got[k].stamp, 64'h1234);
		end
		clr();
		cfg[5].rate_div = 8'h3;
		cyc(3);
		ddc_strobe = 8'h20;
		cyc(1);
		ddc_strobe = 8'h0;
		cyc(6);
		chk(cfg_error, 0);
		chk(sr_sink_i.got.size(), 1);
		chk(sr_sink_i.port[0], 5);
		chk(sr_sink_i.got[0].ddc, 5);
		clr();
		cfg[0].mux_mask = 8'h02;
		cfg[1].rate_div = 8'h2;
		cyc(3);
		chk(cfg_error[0], 1);
		cfg[1].rate_div = 8'h1;
		cfg[0].mux_mask = 8'h0;
		cfg[0].sync_mask = 8'h3e;
		cyc(3);
		chk(cfg_error[0], 1);
		cfg[0].sync_mask = 8'h1e;
		cyc(3);
		chk(cfg_error[0], 0);
		cfg[0].sync_mask = 8'h0;
		cfg[0].mux_mask = 8'hfe;
		cyc(3);
		chk(cfg_error[0], 0);
		clr();
		cfg[0].sync_mask = 8'h02;
		cfg[0].mux_mask = 8'h04;
		cfg[0].phase_inc = 32'h11111111;
		cfg[1].phase_inc = 32'h22222222;
		cfg[2].phase_inc = 32'h33333333;
		cyc(1);
		chk(ddc_phase_load, 8'h07);
		cyc(2);
		chk(ddc_phase_load, 8'h00);
		chk(ddc_phase[1], 32'h11111111);
		chk(ddc_phase[2], 32'h33333333);
		// A reset in mid-run clears the phase words, which then reload.
		rst_b = 1'b0;
		cyc(1);
		chk(ddc_phase[1], 32'h0);
		chk(ddc_phase_load, 8'h00);
		rst_b = 1'b1;
		cyc(2);
		chk(ddc_phase[1], 32'h11111111);
		end_sim();
	end
endmodule

// [tb/sr_sink.sv]
// Partner model: the port FIFOs that take routed words from the block.
// Assumes the clock of the block; stall holds every FIFO off at once.
`timescale 1ns/1ns
`include "sdr_route_map.svh"

module sr_sink
(
	input  wire logic                   clk,
	input  wire logic                   stall,
	input  wire sr_pkg::sr_word_s       port_word [`SR_NUM_DDC],
	output      logic [`SR_NUM_DDC-1:0] port_ready
);
	import sr_pkg::*;

	// ****************************************
	// Capture
	// ****************************************
	// Words are logged with their port so the bench can check routing.
	sr_word_s got [$];
	int       port [$];

	assign port_ready = {`SR_NUM_DDC{~stall}};

	always @(posedge clk)
	begin
		for (int b = 0; b < `SR_NUM_DDC; b++)
			if (port_word[b].valid && port_ready[b])
			begin
				got.push_back(port_word[b]);
				port.push_back(b);
			end
	end
endmodule
